// File: hw/debug_pass_flag_a_regs.vh
// Purpose: Offsets, field positions, reset values and timing counts of the debug gate.
// Assumes: 32-bit register port, byte addresses, clock of 25 MHz.
// Notes:   Definitions only.
//
// Behaviour
// - In debug mode, boost to normal and normal to boost requests are refused.
// - Normal/back-bias changes in debug mode only flip flags; real power stays normal.
// - Low-power entry is allowed in debug mode; emulator sets debugger enable first.
// - Writing the wake bit in snooze or standby states wakes the chip.
// - Halt bit with wake wakes the chip but keeps the processor stopped.
// - In debug mode, bus access only in operating or sleep, never in deep states or transitions.
// - A new unlock code takes effect only at pin reset; a system reset request never loads it.
// - Once all four key words are written, system reset requests are ignored.
// - After pin release, wait a set interval before comparing code and key.
// - Stored code with top bit zero always mismatches and blocks the emulator.
// - An all-ones stored code opens bus access with no key.
// - System bus access port is DAP port 0, debug register port is port 1.
// - Stored code equal to the erase key erases flash, then sets clock-stopped.
// - On match, bus port is authorised; result shows in status and port status.
// - Port status is 1 and transfers pass on match, 0 and blocked on mismatch.
// - The full 128-bit key is compared bit for bit with the stored code.
// - Halt bit halts the processor; cleared by writing 0 or by the halt.
`ifndef DEBUG_PASS_FLAG_A_REGS_VH
`define DEBUG_PASS_FLAG_A_REGS_VH

`define ADDR_W            8
`define KEY_WORD0_OFS     8'h00
`define KEY_WORD1_OFS     8'h04
`define KEY_WORD2_OFS     8'h08
`define KEY_WORD3_OFS     8'h0C
`define DEBUGGER_CTRL_OFS 8'h10
`define CHIP_CTRL_OFS     8'h14
`define CHIP_STATUS_OFS   8'h18

`define DEBUGGER_EN_BIT     0
`define CTRL_HALT_BIT       0
`define CTRL_WAKE_BIT       8
`define STAT_PASS_BIT       0
`define STAT_CLKSTOP_BIT    1
`define STAT_CMPVALID_BIT   2
`define STAT_KEYSFULL_BIT   3

`define CODE_RESET  128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF
`define ERASE_KEY   128'h414C_6552_4153_45FF_FFFF_FFFF_FFFF_FFFF

// Power control modes.
`define PC_BOOST    2'h0
`define PC_NORMAL   2'h1
`define PC_BIAS     2'h2

// Low power states.
`define LP_OPER     3'h0
`define LP_SLEEP    3'h1
`define LP_SNOOZE   3'h2
`define LP_SWSTBY   3'h3
`define LP_DEEP     3'h4

// Wait after reset pin release before comparing, in ns, and as cycles of 40 ns.
`define CLK_NS          40
`define CMP_WAIT_NS     1000
`define CMP_WAIT_CYC    ((`CMP_WAIT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// File: hw/pin_sync.v
// Purpose: Two-stage synchroniser for pins entering the clock domain.
// Assumes: Inputs are asynchronous levels.
// Notes:   First stage feeds only the second.
`default_nettype none
module pin_sync #(
   parameter W   = 1,
   parameter INI = 1'b0
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst,
   // Levels
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         always @(posedge clk) begin
            if (rst) begin
               meta_q <= INI;
               sync_q <= INI;
            end else begin
               meta_q <= async_in[i];
               sync_q <= meta_q;
            end
         end
         assign sync_out[i] = sync_q;
      end
   endgenerate
endmodule
`default_nettype wire

// File: hw/code_store.v
// Purpose: Holds the stored unlock code and replaces it on a reset event.
// Assumes: load is a one-cycle pulse from the gate.
// Notes:   Read data come straight from the register.
`include "debug_pass_flag_a_regs.vh"
`default_nettype none
module code_store (
   // Clock and reset
   input  wire         clk,
   input  wire         rst,
   // Update
   input  wire         load,
   input  wire [127:0] new_code,
   // Stored value
   output reg  [127:0] code_q
);
   // The old code stays in force until the reset event itself.
   always @(posedge clk) begin
      if (rst)
         code_q <= `CODE_RESET;
      else if (load)
         code_q <= new_code;
   end
endmodule
`default_nettype wire

// File: hw/debug_pass_flag_a_gate.v
// Purpose: Key check, bus access gating, erase trigger and power gating for debug mode.
// Assumes: Chip-side status inputs share clk; pins and the link clock are asynchronous.
// Notes:   The link clock is sampled, not used as a clock.
`include "debug_pass_flag_a_regs.vh"
`default_nettype none
module debug_pass_flag_a_gate #(
   parameter CNT_W = 16
) (
   // Clock and reset
   input  wire                clk,
   input  wire                rst,
   // Register port
   input  wire [`ADDR_W-1:0]  reg_addr,
   input  wire [31:0]         reg_wdata,
   input  wire                reg_we,
   input  wire                reg_re,
   output reg  [31:0]         reg_rdata_q,
   // Pins
   input  wire                reset_pin_n,
   input  wire                swclk,
   input  wire                pwrup_req,
   // Debug port side
   input  wire                ap_sel,
   output reg                 pwrup_ack_q,
   output reg                 ahb_ap_sel_q,
   output reg                 apb_ap_sel_q,
   output reg                 dbg_status_q,
   output reg                 ahb_enable_q,
   output reg                 emulator_block_q,
   // Chip state
   input  wire                on_chip_debug_mode,
   input  wire [2:0]          lp_state,
   input  wire                mode_transition,
   input  wire                cpu_halted,
   input  wire                sys_reset_req,
   input  wire                erase_done,
   // Power control requests
   input  wire                pc_req,
   input  wire [1:0]          pc_target,
   input  wire                lp_entry_req,
   output reg                 pc_apply_q,
   output reg  [1:0]          pc_apply_mode_q,
   output reg                 pc_refused_q,
   output reg  [1:0]          pc_mode_flag_q,
   output reg                 lp_entry_grant_q,
   // Chip control
   output reg                 chip_reset_q,
   output reg                 cpu_halt_req_q,
   output reg                 wake_req_q,
   output reg                 cpu_start_inhibit_q,
   output reg                 flash_erase_q,
   output reg                 debugger_enable_q
);
   localparam integer     CMP_WAIT_I = `CMP_WAIT_CYC;
   localparam [CNT_W-1:0] CMP_WAIT   = CMP_WAIT_I[CNT_W-1:0];

   wire [2:0]   sync_s;
   wire         pin_s  = sync_s[0];
   wire         clk_s  = sync_s[1];
   wire         pwr_s  = sync_s[2];
   wire [127:0] code;

   reg  [31:0]      key_q [0:3];
   reg  [3:0]       key_wr_q;
   reg              pin_d1_q;
   reg              clk_d1_q;
   reg              link_seen_q;
   reg  [CNT_W-1:0] wait_q;
   reg              cmp_valid_q;
   reg              clkstop_q;
   reg              halt_q;
   reg              wake_q;
   reg  [1:0]       pc_mode_q;

   wire keys_full  = &key_wr_q;
   wire pin_fall   = pin_d1_q & ~pin_s;
   wire pin_rise   = ~pin_d1_q & pin_s;
   wire sysreq_ok  = sys_reset_req & ~keys_full;
   wire reset_evt  = pin_fall | sysreq_ok;
   wire [127:0] key_all = {key_q[0], key_q[1], key_q[2], key_q[3]};

   // Only a fully written key replaces the stored code.
   wire code_load = reset_evt & keys_full;

   wire open_code  = &code;
   wire key_match  = (key_all == code) & code[127];
   wire erase_code = (code == `ERASE_KEY);
   wire access_ok  = cmp_valid_q & (open_code | key_match);
   wire lp_deep    = (lp_state == `LP_SNOOZE) | (lp_state == `LP_SWSTBY) |
                     (lp_state == `LP_DEEP);
   wire bus_ok     = ~mode_transition &
                     ((lp_state == `LP_OPER) | (lp_state == `LP_SLEEP));

   wire sel_key0 = reg_addr == `KEY_WORD0_OFS;
   wire sel_key1 = reg_addr == `KEY_WORD1_OFS;
   wire sel_key2 = reg_addr == `KEY_WORD2_OFS;
   wire sel_key3 = reg_addr == `KEY_WORD3_OFS;
   wire wr_ctrl  = reg_we & (reg_addr == `CHIP_CTRL_OFS);
   wire [3:0] key_sel = {sel_key3, sel_key2, sel_key1, sel_key0};

   pin_sync #(
      .W   (3),
      .INI (1'b0)
   ) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({pwrup_req, swclk, reset_pin_n}),
      .sync_out (sync_s)
   );

   code_store u_code (
      .clk      (clk),
      .rst      (rst),
      .load     (code_load),
      .new_code (key_all),
      .code_q   (code)
   );

   // Key entry words; word 0 is the most significant part of the key.
   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1) begin : g_key
         always @(posedge clk) begin
            if (rst) begin
               key_q[k]    <= 32'h0000_0000;
               key_wr_q[k] <= 1'b0;
            end else if (reg_we & key_sel[k]) begin
               key_q[k]    <= reg_wdata;
               key_wr_q[k] <= 1'b1;
            end else if (reset_evt) begin
               key_wr_q[k] <= 1'b0;
            end
         end
      end
   endgenerate

   // Reset pin tracking and the settle wait before the comparison.
   always @(posedge clk) begin
      if (rst) begin
         pin_d1_q     <= 1'b0;
         chip_reset_q <= 1'b1;
         wait_q       <= {CNT_W{1'b0}};
         cmp_valid_q  <= 1'b0;
      end else begin
         pin_d1_q     <= pin_s;
         chip_reset_q <= ~pin_s | sysreq_ok;
         if (~pin_s | pin_fall) begin
            cmp_valid_q <= 1'b0;
            wait_q      <= {CNT_W{1'b0}};
         end else if (pin_rise) begin
            wait_q      <= CMP_WAIT;
         end else if (sysreq_ok) begin
            // A soft reset keeps the supply stable, so no settle wait is needed.
            cmp_valid_q <= 1'b0;
            wait_q      <= {{(CNT_W-1){1'b0}}, 1'b1};
         end else if (wait_q != {CNT_W{1'b0}}) begin
            wait_q <= wait_q - {{(CNT_W-1){1'b0}}, 1'b1};
            if (wait_q == {{(CNT_W-1){1'b0}}, 1'b1})
               cmp_valid_q <= 1'b1;
         end
      end
   end

   // Authentication result and bus gating.
   always @(posedge clk) begin
      if (rst) begin
         dbg_status_q     <= 1'b0;
         ahb_enable_q     <= 1'b0;
         emulator_block_q <= 1'b0;
         ahb_ap_sel_q     <= 1'b0;
         apb_ap_sel_q     <= 1'b0;
      end else begin
         dbg_status_q     <= access_ok;
         ahb_enable_q     <= access_ok & (bus_ok | ~on_chip_debug_mode);
         emulator_block_q <= cmp_valid_q & ~code[127];
         ahb_ap_sel_q     <= ~ap_sel & access_ok;
         apb_ap_sel_q     <= ap_sel & ~(cmp_valid_q & ~code[127]);
      end
   end

   // Erase on the erase key; the stopped-clock flag marks completion.
   always @(posedge clk) begin
      if (rst) begin
         flash_erase_q <= 1'b0;
         clkstop_q     <= 1'b0;
      end else if (reset_evt) begin
         flash_erase_q <= 1'b0;
         clkstop_q     <= 1'b0;
      end else begin
         if (flash_erase_q & erase_done) begin
            flash_erase_q <= 1'b0;
            clkstop_q     <= 1'b1;
         end else if (cmp_valid_q & erase_code & ~clkstop_q) begin
            flash_erase_q <= 1'b1;
         end
      end
   end

   // Link activity and debug power-up acknowledge.
   always @(posedge clk) begin
      if (rst) begin
         clk_d1_q    <= 1'b0;
         link_seen_q <= 1'b0;
         pwrup_ack_q <= 1'b0;
      end else begin
         clk_d1_q <= clk_s;
         if (clk_s & ~clk_d1_q)
            link_seen_q <= 1'b1;
         // The acknowledge follows the request once the link has clocked at least once.
         pwrup_ack_q <= pwr_s & link_seen_q;
      end
   end

   // Halt and wake control bits; a write wins over the hardware clear in the same cycle.
   always @(posedge clk) begin
      if (rst) begin
         halt_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         if (wr_ctrl)
            halt_q <= reg_wdata[`CTRL_HALT_BIT];
         else if (cpu_halted)
            halt_q <= 1'b0;
         if (wr_ctrl)
            wake_q <= reg_wdata[`CTRL_WAKE_BIT];
         else if (~lp_deep)
            wake_q <= 1'b0;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         cpu_halt_req_q      <= 1'b0;
         wake_req_q          <= 1'b0;
         cpu_start_inhibit_q <= 1'b0;
      end else begin
         cpu_halt_req_q      <= halt_q;
         wake_req_q          <= wake_q & lp_deep;
         cpu_start_inhibit_q <= wake_q & halt_q;
      end
   end

   // Power control gating.
   always @(posedge clk) begin
      if (rst) begin
         pc_mode_q        <= `PC_NORMAL;
         pc_mode_flag_q   <= `PC_NORMAL;
         pc_apply_q       <= 1'b0;
         pc_apply_mode_q  <= `PC_NORMAL;
         pc_refused_q     <= 1'b0;
         lp_entry_grant_q <= 1'b0;
      end else begin
         pc_apply_q       <= 1'b0;
         pc_refused_q     <= 1'b0;
         lp_entry_grant_q <= lp_entry_req;
         if (pc_req) begin
            if (~on_chip_debug_mode) begin
               pc_mode_q       <= pc_target;
               pc_mode_flag_q  <= pc_target;
               pc_apply_q      <= 1'b1;
               pc_apply_mode_q <= pc_target;
            end else if ((pc_mode_q == `PC_BOOST) | (pc_target == `PC_BOOST)) begin
               pc_refused_q <= 1'b1;
            end else begin
               // Supply stays at normal so the debug link survives the change.
               pc_mode_q      <= pc_target;
               pc_mode_flag_q <= pc_target;
            end
         end
      end
   end

   // Register writes and reads.
   always @(posedge clk) begin
      if (rst)
         debugger_enable_q <= 1'b0;
      else if (reg_we & (reg_addr == `DEBUGGER_CTRL_OFS))
         debugger_enable_q <= reg_wdata[`DEBUGGER_EN_BIT];
   end

   always @(posedge clk) begin
      if (rst) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= 32'h0000_0000;
         if (reg_re) begin
            case (reg_addr)
               `DEBUGGER_CTRL_OFS:
                  reg_rdata_q[`DEBUGGER_EN_BIT] <= debugger_enable_q;
               `CHIP_CTRL_OFS: begin
                  reg_rdata_q[`CTRL_HALT_BIT] <= halt_q;
                  reg_rdata_q[`CTRL_WAKE_BIT] <= wake_q;
               end
               `CHIP_STATUS_OFS: begin
                  reg_rdata_q[`STAT_PASS_BIT]     <= access_ok;
                  reg_rdata_q[`STAT_CLKSTOP_BIT]  <= clkstop_q;
                  reg_rdata_q[`STAT_CMPVALID_BIT] <= cmp_valid_q;
                  reg_rdata_q[`STAT_KEYSFULL_BIT] <= keys_full;
               end
               default:
                  reg_rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/debug_pass_flag_a_gate_sva.sv
// Purpose: Concurrent checks on the ports of the debug gate.
// Assumes: One clock domain; rst is synchronous and active high.
// Notes:   Registered outputs are judged one cycle after the inputs that cause them; the halt request is judged two cycles after.
`include "debug_pass_flag_a_regs.vh"
`default_nettype none
module debug_pass_flag_a_gate_sva (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Inputs watched
   input wire logic       ap_sel,
   input wire logic       on_chip_debug_mode,
   input wire logic [2:0] lp_state,
   input wire logic       mode_transition,
   input wire logic       cpu_halted,
   input wire logic       erase_done,
   input wire logic       pc_req,
   input wire logic [1:0] pc_target,
   input wire logic       lp_entry_req,
   input wire logic       reg_we,
   // Outputs watched
   input wire logic       ahb_ap_sel_q,
   input wire logic       apb_ap_sel_q,
   input wire logic       dbg_status_q,
   input wire logic       ahb_enable_q,
   input wire logic       emulator_block_q,
   input wire logic       pc_apply_q,
   input wire logic       pc_refused_q,
   input wire logic [1:0] pc_mode_flag_q,
   input wire logic       lp_entry_grant_q,
   input wire logic       cpu_halt_req_q,
   input wire logic       wake_req_q,
   input wire logic       flash_erase_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_boost_refused;
      pc_req && on_chip_debug_mode && pc_target == `PC_BOOST |=> pc_refused_q && !pc_apply_q;
   endproperty
   a_boost_refused: assert property (p_boost_refused)
      else $error("boost change applied");
   property p_bias_flag;
      pc_req && on_chip_debug_mode && pc_target == `PC_BIAS && pc_mode_flag_q == `PC_NORMAL
         |=> !pc_apply_q && pc_mode_flag_q == `PC_BIAS;
   endproperty
   a_bias_flag: assert property (p_bias_flag)
      else $error("back-bias change not emulated");
   property p_lp_grant;
      lp_entry_req |=> lp_entry_grant_q;
   endproperty
   a_lp_grant: assert property (p_lp_grant) else $error("low-power entry not granted");
   property p_wake_deep;
      wake_req_q |-> $past(lp_state) inside {`LP_SNOOZE, `LP_SWSTBY, `LP_DEEP};
   endproperty
   a_wake_deep: assert property (p_wake_deep)
      else $error("wake outside standby states");
   property p_bus_deny;
      (on_chip_debug_mode && (lp_state >= `LP_SNOOZE || mode_transition)) [*2]
         |-> !ahb_enable_q;
   endproperty
   a_bus_deny: assert property (p_bus_deny) else $error("bus open in deep state");
   property p_block;
      emulator_block_q |-> !dbg_status_q && !ahb_ap_sel_q && !ahb_enable_q;
   endproperty
   a_block: assert property (p_block) else $error("blocked emulator still passes");
   property p_status_gate;
      !dbg_status_q |-> !ahb_enable_q && !ahb_ap_sel_q;
   endproperty
   a_status_gate: assert property (p_status_gate) else $error("bus open on mismatch");
   property p_port_map;
      ahb_ap_sel_q || apb_ap_sel_q
         |-> apb_ap_sel_q == $past(ap_sel) && ahb_ap_sel_q != apb_ap_sel_q;
   endproperty
   a_port_map: assert property (p_port_map) else $error("access port numbering wrong");
   property p_halt_clear;
      cpu_halted && !reg_we |-> ##2 !cpu_halt_req_q;
   endproperty
   a_halt_clear: assert property (p_halt_clear)
      else $error("halt request kept after halt");
   property p_erase_done;
      flash_erase_q && erase_done |=> !flash_erase_q;
   endproperty
   a_erase_done: assert property (p_erase_done) else $error("erase kept after done");
endmodule
`default_nettype wire

// File: dv/emulator_model.sv
// Purpose: Emulator side of the link: link clock frames and the power-up handshake.
// Assumes: The acknowledge is a level from the gate.
// Notes:   The link clock stands low outside frames, like an idle probe.
`default_nettype none
module emulator_model (
   // Link
   output var logic swclk,
   output var logic pwrup_req,
   // Answer
   input wire logic pwrup_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      swclk = 1'b0;
      pwrup_req = 1'b0;
   end
   // The odd start offset keeps link edges away from the gate's clock edges.
   task automatic connect(output logic ok);
      #7 pwrup_req = 1'b1;
      ok = 1'b0;
      for (int i = 0; i < 8 && ok !== 1'b1; i++) begin
         #160 swclk = 1'b1;
         #160 swclk = 1'b0;
         ok = pwrup_ack;
      end
   endtask
endmodule
`default_nettype wire

// File: dv/debug_pass_flag_a_gate_tb_top.sv
// Purpose: Self-checking bench for the debug gate with an emulator model on the link.
// Assumes: Gate, synchroniser and code store are compiled first.
// Notes:   Keys come from a fixed seed; erase, block and refusal cases are written by hand.
`include "debug_pass_flag_a_regs.vh"
`default_nettype none
module debug_pass_flag_a_gate_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic               clk, rst, reg_we, reg_re, reset_pin_n, ap_sel, mode_transition;
   logic               cpu_halted, sys_reset_req, erase_done, pc_req, lp_entry_req, swclk;
   logic               pwrup_req, pwrup_ack_q, ahb_ap_sel_q, apb_ap_sel_q, dbg_status_q;
   logic               ahb_enable_q, emulator_block_q, pc_apply_q, pc_refused_q, chip_reset_q;
   logic               lp_entry_grant_q, cpu_halt_req_q, wake_req_q, cpu_start_inhibit_q;
   logic               flash_erase_q, debugger_enable_q, ok, r_ap, r_tr, r_o, on_chip_debug_mode;
   logic [`ADDR_W-1:0] reg_addr;
   logic [31:0]        reg_wdata, reg_rdata_q, d;
   logic [2:0]         lp_state, r_lp;
   logic [1:0]         pc_target, pc_apply_mode_q, pc_mode_flag_q;
   logic [127:0]       key;
   logic [7:0]         pc_tbl [6];
   integer             seed, mismatches, total_checks;
   debug_pass_flag_a_gate dut_u (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata_q(reg_rdata_q), .reset_pin_n(reset_pin_n), .swclk(swclk),
      .pwrup_req(pwrup_req), .ap_sel(ap_sel), .pwrup_ack_q(pwrup_ack_q),
      .ahb_ap_sel_q(ahb_ap_sel_q), .apb_ap_sel_q(apb_ap_sel_q), .dbg_status_q(dbg_status_q),
      .ahb_enable_q(ahb_enable_q), .emulator_block_q(emulator_block_q),
      .on_chip_debug_mode(on_chip_debug_mode),
      .lp_state(lp_state), .mode_transition(mode_transition), .cpu_halted(cpu_halted),
      .sys_reset_req(sys_reset_req), .erase_done(erase_done), .pc_req(pc_req),
      .pc_target(pc_target), .lp_entry_req(lp_entry_req), .pc_apply_q(pc_apply_q),
      .pc_apply_mode_q(pc_apply_mode_q), .pc_refused_q(pc_refused_q),
      .pc_mode_flag_q(pc_mode_flag_q), .lp_entry_grant_q(lp_entry_grant_q),
      .chip_reset_q(chip_reset_q), .cpu_halt_req_q(cpu_halt_req_q), .wake_req_q(wake_req_q),
      .cpu_start_inhibit_q(cpu_start_inhibit_q), .flash_erase_q(flash_erase_q),
      .debugger_enable_q(debugger_enable_q)
   );
   emulator_model emu_u (.swclk(swclk), .pwrup_req(pwrup_req), .pwrup_ack(pwrup_ack_q));
   always #20 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tend(input string nm);
      $display("test %s done", nm);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 v = reg_rdata_q;
   endtask
   task automatic wkey(input logic [127:0] k);
      for (int i = 0; i < 4; i++) wr(8'(4 * i), k[127 - 32 * i -: 32]);
   endtask
   task automatic pin_reset();
      @(posedge clk);
      reset_pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk("chip_reset", {31'h0, chip_reset_q}, 32'h1);
      reset_pin_n <= 1'b1;
      rd(`CHIP_STATUS_OFS, d);
      chk("early compare", d & 32'h4, 32'h0);
      repeat (`CMP_WAIT_CYC + 8) @(posedge clk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      mismatches++;
      test_done();
   end
   initial begin
      seed = 32'h8a03;
      mismatches = 0;
      total_checks = 0;
      {clk, reg_we, reg_re, ap_sel, mode_transition, cpu_halted} = 6'h0;
      {sys_reset_req, erase_done, pc_req, lp_entry_req} = 4'h0;
      {rst, reset_pin_n, on_chip_debug_mode} = 3'h7;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      lp_state = `LP_OPER;
      pc_target = `PC_NORMAL;
      // Each entry: debug mode, target, then refused, apply, visible mode, grant.
      pc_tbl = '{8'hC5, 8'hA3, 8'h93, 8'h09, 8'hB1, 8'h2B};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      emu_u.connect(ok);
      chk("pwrup_ack", {31'h0, ok}, 32'h1);
      pin_reset();
      rd(`CHIP_STATUS_OFS, d);
      chk("open status", d, 32'h0000_0005);
      rd(8'h1C, d);
      chk("unmapped", d, 32'h0);
      rd(`KEY_WORD0_OFS, d);
      chk("key word read", d, 32'h0);
      @(posedge clk);
      sys_reset_req <= 1'b1;
      @(posedge clk);
      sys_reset_req <= 1'b0;
      #1 chk("sys reset taken", {31'h0, chip_reset_q}, 32'h1);
      key = {$random(seed), $random(seed), $random(seed), $random(seed)};
      key[127] = 1'b1;
      wkey(key);
      @(posedge clk);
      sys_reset_req <= 1'b1;
      @(posedge clk);
      sys_reset_req <= 1'b0;
      #1 chk("sys reset ignored", {31'h0, chip_reset_q}, 32'h0);
      rd(`CHIP_STATUS_OFS, d);
      chk("old code kept", d, 32'h0000_000D);
      tend("open code");
      pin_reset();
      wkey(key ^ 128'h1);
      repeat (3) @(posedge clk);
      chk("mismatch", {30'h0, dbg_status_q, ahb_enable_q}, 32'h0);
      wr(`KEY_WORD3_OFS, key[31:0]);
      repeat (3) @(posedge clk);
      chk("match", {30'h0, dbg_status_q, ahb_enable_q}, 32'h3);
      rd(`CHIP_STATUS_OFS, d);
      chk("pass flag", d & 32'h1, 32'h1);
      wr(`DEBUGGER_CTRL_OFS, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk("dbg enable", {31'h0, debugger_enable_q}, 32'h1);
      for (int i = 0; i < 16; i++) begin
         {r_ap, r_tr, r_o} = 3'($random(seed));
         r_lp = 3'($unsigned($random(seed)) % 5);
         @(posedge clk);
         {ap_sel, mode_transition, on_chip_debug_mode, lp_state} <= {r_ap, r_tr, r_o, r_lp};
         repeat (3) @(posedge clk);
         chk("bus gate", {29'h0, ahb_enable_q, ahb_ap_sel_q, apb_ap_sel_q},
             {29'h0, !r_o || (r_lp < 2 && !r_tr), !r_ap, r_ap});
      end
      @(posedge clk);
      {ap_sel, mode_transition, on_chip_debug_mode, lp_state} <= {3'b001, `LP_OPER};
      tend("key match");
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         {on_chip_debug_mode, pc_target, pc_req, lp_entry_req} <= {pc_tbl[i][7:5], 2'b11};
         @(posedge clk);
         {pc_req, lp_entry_req} <= 2'b00;
         #1 chk("power", {27'h0, pc_refused_q, pc_apply_q, pc_mode_flag_q, lp_entry_grant_q},
                {27'h0, pc_tbl[i][4:0]});
         if (pc_tbl[i][3])
            chk("apply mode", {30'h0, pc_apply_mode_q}, {30'h0, pc_tbl[i][6:5]});
      end
      @(posedge clk);
      {on_chip_debug_mode, lp_state} <= {1'b1, `LP_SWSTBY};
      wr(`CHIP_CTRL_OFS, 32'h0000_0101);
      repeat (3) @(posedge clk);
      chk("wake", {29'h0, wake_req_q, cpu_halt_req_q, cpu_start_inhibit_q},
          32'h7);
      cpu_halted <= 1'b1;
      @(posedge clk);
      cpu_halted <= 1'b0;
      repeat (3) @(posedge clk);
      chk("halt clear", {31'h0, cpu_halt_req_q}, 32'h0);
      rd(`CHIP_CTRL_OFS, d);
      chk("ctrl read", d, 32'h0000_0100);
      lp_state <= `LP_OPER;
      wr(`DEBUGGER_CTRL_OFS, 32'h0);
      tend("power and wake");
      wkey(`ERASE_KEY);
      pin_reset();
      chk("erase start", {31'h0, flash_erase_q}, 32'h1);
      erase_done <= 1'b1;
      @(posedge clk);
      erase_done <= 1'b0;
      rd(`CHIP_STATUS_OFS, d);
      chk("erase end", {30'h0, flash_erase_q, d[1]}, 32'h1);
      tend("erase");
      key[127] = 1'b0;
      wkey(key);
      pin_reset();
      wkey(key);
      repeat (3) @(posedge clk);
      chk("blocked", {29'h0, emulator_block_q, dbg_status_q, ahb_enable_q}, 32'h4);
      tend("blocked code");
      test_done();
   end
endmodule
bind debug_pass_flag_a_gate debug_pass_flag_a_gate_sva sva_u (
   .clk(clk), .rst(rst), .ap_sel(ap_sel), .lp_state(lp_state),
   .on_chip_debug_mode(on_chip_debug_mode),
   .mode_transition(mode_transition), .cpu_halted(cpu_halted), .erase_done(erase_done),
   .pc_req(pc_req), .pc_target(pc_target), .lp_entry_req(lp_entry_req), .reg_we(reg_we),
   .ahb_ap_sel_q(ahb_ap_sel_q), .apb_ap_sel_q(apb_ap_sel_q), .dbg_status_q(dbg_status_q),
   .ahb_enable_q(ahb_enable_q), .emulator_block_q(emulator_block_q), .pc_apply_q(pc_apply_q),
   .pc_refused_q(pc_refused_q), .pc_mode_flag_q(pc_mode_flag_q),
   .lp_entry_grant_q(lp_entry_grant_q), .cpu_halt_req_q(cpu_halt_req_q),
   .wake_req_q(wake_req_q), .flash_erase_q(flash_erase_q)
);
`default_nettype wire
